// [rtl/pbau_regs.svh]
`ifndef PBAU_REGS_SVH
`define PBAU_REGS_SVH

// register byte addresses
`define PBAU_ADDR_CMD 8'h00
`define PBAU_ADDR_ACC 8'h04
`define PBAU_ADDR_STACK1 8'h08
`define PBAU_ADDR_OPERAND 8'h0c
`define PBAU_ADDR_RANGE 8'h10
`define PBAU_ADDR_FLAGS 8'h14
`define PBAU_ADDR_STATUS 8'h18
`define PBAU_ADDR_MASK 8'h1c
`define PBAU_ADDR_STATE 8'h20

// command register fields
`define PBAU_CMD_OP_LSB 0
`define PBAU_CMD_OP_W 3
`define PBAU_CMD_IMM_BIT 4

// operation codes
`define PBAU_OP_DIV 3'h1
`define PBAU_OP_INC 3'h2
`define PBAU_OP_DEC 3'h3
`define PBAU_OP_BADD 3'h4
`define PBAU_OP_BSUB 3'h5

// bit range register fields
`define PBAU_RANGE_START_LSB 0
`define PBAU_RANGE_LEN_LSB 8
`define PBAU_RANGE_FIELD_W 8
`define PBAU_LEN_MIN 8'h01
`define PBAU_LEN_MAX 8'h20

// flag register bit positions
`define PBAU_FLAG_RANGE 0
`define PBAU_FLAG_ZERO 1
`define PBAU_FLAG_SBORROW 2
`define PBAU_FLAG_LBORROW 3
`define PBAU_FLAG_SCARRY 4
`define PBAU_FLAG_LCARRY 5
`define PBAU_FLAG_NEG 6
`define PBAU_FLAG_OVF 7
`define PBAU_FLAG_INVDIG 8
`define PBAU_FLAG_W 9

// interrupt status bit positions
`define PBAU_ST_DONE 0
`define PBAU_ST_RANGE 1
`define PBAU_ST_INVDIG 2
`define PBAU_ST_REFUSED 3
`define PBAU_ST_W 4

// reset values
`define PBAU_RST_WORD 32'h0000_0000
`define PBAU_RST_FLAGS 9'h000
`define PBAU_RST_ST 4'h0
`define PBAU_RST_HALF 16'h0000
`define PBAU_RST_OP 3'h0

// bcd digit constants
`define PBAU_BCD_NINE 5'h09
`define PBAU_BCD_ADJ 5'h06
`define PBAU_BCD_TEN 5'h0a
`define PBAU_DIGITS 8
`define PBAU_SHORT_DIGIT 3

`endif

// [rtl/pbau_pkg.sv]
package pbau_pkg;

	// sequencing states, one-hot
	typedef enum logic [3:0] {
		PBAU_IDLE = 4'h1,
		PBAU_MRD = 4'h2,
		PBAU_EXEC = 4'h4,
		PBAU_MWR = 4'h8
	} pbau_state_t;

endpackage : pbau_pkg

// [rtl/pbau_arith_unit.sv]
`timescale 1ns/100ps
// Notes on behaviour
// - divide acc by word; remainder to stack
// - oversize divisor raises operand range flag
// - zero flag follows each result
// - negative flag after divide, bcd add/sub
// - flags change only when op affects them
// - increment memory word by one, write back
// - decrement memory word by one, write back
// - bcd add bit-range operand into acc
// - bcd subtract bit-range operand from acc
// - bit-range length one to thirty-two bits
// - short carry from 16-bit addition
// - long carry from 32-bit addition
// - sign overflow on wrong result sign
// - invalid digit flag for non-bcd nibble
// - short borrow from 16-bit subtraction
// - long borrow from 32-bit subtraction
`include "pbau_regs.svh"

module pbau_arith_unit import pbau_pkg::*; #(
	parameter int MEM_AW = 16, // data memory word address width
	parameter int DISC_W = 256 // size of the discrete bit image
) (
	input wire logic clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// data memory port, one cycle read latency
	output logic mem_rd,
	output logic mem_wr,
	output logic [MEM_AW-1:0] mem_addr,
	output logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata,
	// discrete bit image
	input wire logic [DISC_W-1:0] disc_bits,
	// interrupt
	output logic irq
);

	// bcd result: {long carry, short carry, sum}
	function automatic logic [33:0] bcd_add(input logic [31:0] a, input logic [31:0] b);
		logic [4:0] d;
		logic c;
		logic c16;
		logic [31:0] s;
		c = 1'b0;
		c16 = 1'b0;
		s = `PBAU_RST_WORD;
		for (int i = 0; i < `PBAU_DIGITS; i++) begin
			d = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, c};
			// decimal adjust a digit above nine
			if (d > `PBAU_BCD_NINE) begin
				d = d + `PBAU_BCD_ADJ;
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			s[i*4+:4] = d[3:0];
			if (i == `PBAU_SHORT_DIGIT) begin
				c16 = c;
			end
		end
		return {c, c16, s};
	endfunction : bcd_add

	// bcd result: {long borrow, short borrow, difference}
	function automatic logic [33:0] bcd_sub(input logic [31:0] a, input logic [31:0] b);
		logic [4:0] d;
		logic c;
		logic c16;
		logic [31:0] s;
		c = 1'b0;
		c16 = 1'b0;
		s = `PBAU_RST_WORD;
		for (int i = 0; i < `PBAU_DIGITS; i++) begin
			d = {1'b0, a[i*4+:4]} - {1'b0, b[i*4+:4]} - {4'h0, c};
			// digit went negative: borrow ten from the next digit
			if (d[4]) begin
				d = d + `PBAU_BCD_TEN;
				c = 1'b1;
			end else begin
				c = 1'b0;
			end
			s[i*4+:4] = d[3:0];
			if (i == `PBAU_SHORT_DIGIT) begin
				c16 = c;
			end
		end
		return {c, c16, s};
	endfunction : bcd_sub

	// true when any nibble is above nine
	function automatic logic bcd_bad(input logic [31:0] a);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < `PBAU_DIGITS; i++) begin
			if ({1'b0, a[i*4+:4]} > `PBAU_BCD_NINE) begin
				bad = 1'b1;
			end
		end
		return bad;
	endfunction : bcd_bad

	// architectural state
	pbau_state_t state_reg, state_next; // sequencer state
	logic [31:0] acc_reg, acc_next; // accumulator
	logic [31:0] stack1_reg, stack1_next; // first stack level
	logic [31:0] operand_reg, operand_next; // immediate or memory address
	logic [15:0] range_reg, range_next; // bit range start and length
	logic [2:0] op_reg, op_next; // latched operation
	logic imm_reg, imm_next; // divide uses immediate
	logic [`PBAU_FLAG_W-1:0] flags_reg, flags_next; // status flags
	logic [`PBAU_ST_W-1:0] st_reg, st_next; // sticky events
	logic [`PBAU_ST_W-1:0] mask_reg, mask_next; // interrupt mask
	logic [15:0] wdata_reg, wdata_next; // write-back word
	logic [31:0] rdata_reg, rdata_next; // apb read data

	// decoded helpers
	logic apb_wr; // write access phase, takes effect with pready
	logic apb_rd;
	logic apb_hit; // mapped address
	logic [31:0] bitop; // assembled bit-range operand
	logic [7:0] rstart;
	logic [7:0] rlen;

	// zero wait state slave
	assign pready = 1'b1;
	assign apb_wr = psel & penable & pwrite;
	assign apb_rd = psel & ~penable & ~pwrite;
	assign apb_hit = (paddr == `PBAU_ADDR_CMD) || (paddr == `PBAU_ADDR_ACC) ||
		(paddr == `PBAU_ADDR_STACK1) || (paddr == `PBAU_ADDR_OPERAND) ||
		(paddr == `PBAU_ADDR_RANGE) || (paddr == `PBAU_ADDR_FLAGS) ||
		(paddr == `PBAU_ADDR_STATUS) || (paddr == `PBAU_ADDR_MASK) ||
		(paddr == `PBAU_ADDR_STATE);
	assign pslverr = psel & penable & ~apb_hit;
	assign prdata = rdata_reg;

	// memory strobes follow the state
	assign mem_rd = (state_reg == PBAU_MRD);
	assign mem_wr = (state_reg == PBAU_MWR);
	assign mem_addr = operand_reg[MEM_AW-1:0];
	assign mem_wdata = wdata_reg;

	// level interrupt from unmasked sticky bits
	assign irq = |(st_reg & mask_reg);

	assign rstart = range_reg[`PBAU_RANGE_START_LSB+:`PBAU_RANGE_FIELD_W];
	assign rlen = range_reg[`PBAU_RANGE_LEN_LSB+:`PBAU_RANGE_FIELD_W];

	// assemble the operand from the bit image
	always_comb begin
		bitop = `PBAU_RST_WORD;
		for (int i = 0; i < 32; i++) begin
			// first bit lands at bit 0, bits past the length stay zero
			if ((i < int'(rlen)) && ((int'(rstart) + i) < DISC_W)) begin
				bitop[i] = disc_bits[int'(rstart) + i];
			end
		end
	end

	// next-state logic for sequencer, datapath and registers
	always_comb begin
		logic [33:0] br;
		logic [16:0] w;
		logic [15:0] dvs;
		logic [`PBAU_ST_W-1:0] ev;
		logic [`PBAU_ST_W-1:0] clr;
		logic ok_len;
		br = 34'h0;
		w = 17'h0;
		dvs = 16'h0;
		ev = `PBAU_RST_ST;
		clr = `PBAU_RST_ST;
		ok_len = (rlen >= `PBAU_LEN_MIN) && (rlen <= `PBAU_LEN_MAX);
		state_next = state_reg;
		acc_next = acc_reg;
		stack1_next = stack1_reg;
		operand_next = operand_reg;
		range_next = range_reg;
		op_next = op_reg;
		imm_next = imm_reg;
		flags_next = flags_reg;
		mask_next = mask_reg;
		wdata_next = wdata_reg;
		rdata_next = rdata_reg;

		// register writes, ignored for data registers while busy
		if (apb_wr) begin
			case (paddr)
				`PBAU_ADDR_CMD: begin
					if (state_reg == PBAU_IDLE) begin
						op_next = pwdata[`PBAU_CMD_OP_LSB+:`PBAU_CMD_OP_W];
						imm_next = pwdata[`PBAU_CMD_IMM_BIT];
						case (pwdata[`PBAU_CMD_OP_LSB+:`PBAU_CMD_OP_W])
							`PBAU_OP_INC, `PBAU_OP_DEC: begin
								state_next = PBAU_MRD;
							end
							`PBAU_OP_DIV: begin
								state_next = pwdata[`PBAU_CMD_IMM_BIT] ? PBAU_EXEC : PBAU_MRD;
							end
							`PBAU_OP_BADD, `PBAU_OP_BSUB: begin
								// length outside one to thirty-two is refused
								if (ok_len) begin
									state_next = PBAU_EXEC;
								end else begin
									ev[`PBAU_ST_REFUSED] = 1'b1;
								end
							end
							default: begin
								ev[`PBAU_ST_REFUSED] = 1'b1;
							end
						endcase
					end else begin
						ev[`PBAU_ST_REFUSED] = 1'b1;
					end
				end
				`PBAU_ADDR_ACC: begin
					if (state_reg == PBAU_IDLE) begin
						acc_next = pwdata;
					end
				end
				`PBAU_ADDR_STACK1: begin
					if (state_reg == PBAU_IDLE) begin
						stack1_next = pwdata;
					end
				end
				`PBAU_ADDR_OPERAND: begin
					if (state_reg == PBAU_IDLE) begin
						operand_next = pwdata;
					end
				end
				`PBAU_ADDR_RANGE: begin
					if (state_reg == PBAU_IDLE) begin
						range_next = pwdata[15:0];
					end
				end
				`PBAU_ADDR_STATUS: begin
					clr = pwdata[`PBAU_ST_W-1:0];
				end
				`PBAU_ADDR_MASK: begin
					mask_next = pwdata[`PBAU_ST_W-1:0];
				end
				default: begin
					// read-only or unmapped: no effect
				end
			endcase
		end

		// register reads, captured in the setup cycle
		if (apb_rd) begin
			case (paddr)
				`PBAU_ADDR_ACC: rdata_next = acc_reg;
				`PBAU_ADDR_STACK1: rdata_next = stack1_reg;
				`PBAU_ADDR_OPERAND: rdata_next = operand_reg;
				`PBAU_ADDR_RANGE: rdata_next = {16'h0, range_reg};
				`PBAU_ADDR_FLAGS: rdata_next = {23'h0, flags_reg};
				`PBAU_ADDR_STATUS: rdata_next = {28'h0, st_reg};
				`PBAU_ADDR_MASK: rdata_next = {28'h0, mask_reg};
				`PBAU_ADDR_STATE: rdata_next = {28'h0, state_reg};
				default: rdata_next = `PBAU_RST_WORD;
			endcase
		end

		// operation sequencing; flags not named by an op keep their value
		case (state_reg)
			PBAU_IDLE: begin
				// waiting for a command write
			end
			PBAU_MRD: begin
				// memory read strobe issued this cycle
				state_next = PBAU_EXEC;
			end
			PBAU_EXEC: begin
				state_next = PBAU_IDLE;
				ev[`PBAU_ST_DONE] = 1'b1;
				case (op_reg)
					`PBAU_OP_DIV: begin
						dvs = imm_reg ? operand_reg[15:0] : mem_rdata;
						// divisor beyond sixteen bits or zero cannot be worked
						if ((imm_reg && (operand_reg[31:16] != 16'h0)) || (dvs == 16'h0)) begin
							flags_next[`PBAU_FLAG_RANGE] = 1'b1;
							ev[`PBAU_ST_RANGE] = 1'b1;
						end else begin
							flags_next[`PBAU_FLAG_RANGE] = 1'b0;
							acc_next = {16'h0, acc_reg[15:0] / dvs};
							stack1_next = {16'h0, acc_reg[15:0] % dvs};
							flags_next[`PBAU_FLAG_ZERO] = (acc_reg[15:0] / dvs) == 16'h0;
							flags_next[`PBAU_FLAG_NEG] = 1'b0;
						end
					end
					`PBAU_OP_INC, `PBAU_OP_DEC: begin
						// wrap at sixteen bits, write back every time
						if (op_reg == `PBAU_OP_INC) begin
							w = {1'b0, mem_rdata} + 17'h1;
						end else begin
							w = {1'b0, mem_rdata} - 17'h1;
						end
						wdata_next = w[15:0];
						flags_next[`PBAU_FLAG_ZERO] = (w[15:0] == 16'h0);
						state_next = PBAU_MWR;
						ev[`PBAU_ST_DONE] = 1'b0;
					end
					`PBAU_OP_BADD: begin
						br = bcd_add(acc_reg, bitop);
						acc_next = br[31:0];
						flags_next[`PBAU_FLAG_SCARRY] = br[32];
						flags_next[`PBAU_FLAG_LCARRY] = br[33];
						flags_next[`PBAU_FLAG_ZERO] = (br[31:0] == `PBAU_RST_WORD);
						flags_next[`PBAU_FLAG_NEG] = br[31];
						// like signs in, other sign out
						flags_next[`PBAU_FLAG_OVF] = (acc_reg[31] == bitop[31]) && (br[31] != acc_reg[31]);
						flags_next[`PBAU_FLAG_INVDIG] = bcd_bad(acc_reg) | bcd_bad(bitop);
						ev[`PBAU_ST_INVDIG] = bcd_bad(acc_reg) | bcd_bad(bitop);
					end
					`PBAU_OP_BSUB: begin
						br = bcd_sub(acc_reg, bitop);
						acc_next = br[31:0];
						flags_next[`PBAU_FLAG_SBORROW] = br[32];
						flags_next[`PBAU_FLAG_LBORROW] = br[33];
						flags_next[`PBAU_FLAG_ZERO] = (br[31:0] == `PBAU_RST_WORD);
						// negative when the subtrahend exceeded the accumulator
						flags_next[`PBAU_FLAG_NEG] = br[33];
						// unlike signs in, result sign differs from minuend
						flags_next[`PBAU_FLAG_OVF] = (acc_reg[31] != bitop[31]) && (br[31] != acc_reg[31]);
						flags_next[`PBAU_FLAG_INVDIG] = bcd_bad(acc_reg) | bcd_bad(bitop);
						ev[`PBAU_ST_INVDIG] = bcd_bad(acc_reg) | bcd_bad(bitop);
					end
					default: begin
						// unreachable op: just finish
					end
				endcase
			end
			PBAU_MWR: begin
				// write strobe issued this cycle
				state_next = PBAU_IDLE;
				ev[`PBAU_ST_DONE] = 1'b1;
			end
			default: begin
				state_next = PBAU_IDLE;
			end
		endcase

		// sticky events: a new event wins over the clear
		st_next = (st_reg & ~clr) | ev;
	end

	// register every group
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= PBAU_IDLE;
			acc_reg <= `PBAU_RST_WORD;
			stack1_reg <= `PBAU_RST_WORD;
			operand_reg <= `PBAU_RST_WORD;
			range_reg <= `PBAU_RST_HALF;
			op_reg <= `PBAU_RST_OP;
			imm_reg <= 1'b0;
			flags_reg <= `PBAU_RST_FLAGS;
			st_reg <= `PBAU_RST_ST;
			mask_reg <= `PBAU_RST_ST;
			wdata_reg <= `PBAU_RST_HALF;
			rdata_reg <= `PBAU_RST_WORD;
		end else begin
			state_reg <= state_next;
			acc_reg <= acc_next;
			stack1_reg <= stack1_next;
			operand_reg <= operand_next;
			range_reg <= range_next;
			op_reg <= op_next;
			imm_reg <= imm_next;
			flags_reg <= flags_next;
			st_reg <= st_next;
			mask_reg <= mask_next;
			wdata_reg <= wdata_next;
			rdata_reg <= rdata_next;
		end
	end

endmodule : pbau_arith_unit

// [sim/pbau_mem_model.sv]
`timescale 1ns/100ps
// data memory model, one-cycle read latency
module pbau_mem_model (
	input wire logic clk,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic [15:0] mem_rdata
);
	logic [15:0] mem [256]; // word store, low address bits only
	initial begin
		mem_rdata = 16'h5a5a;
	end
	// answer next cycle; otherwise flip so stale data never looks valid
	always @(posedge clk) begin
		if (mem_wr) begin
			mem[mem_addr[7:0]] <= mem_wdata;
		end
		mem_rdata <= mem_rd ? mem[mem_addr[7:0]] : ~mem_rdata;
	end
endmodule : pbau_mem_model

// [sim/pbau_arith_unit_properties.sv]
`timescale 1ns/100ps
`include "pbau_regs.svh"
// memory traffic checks keyed to the last command write
module pbau_arith_unit_props #(
	parameter int MEM_AW = 16
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [MEM_AW-1:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic [15:0] mem_rdata
);
	logic cmd_wr; // command access cycle, where the write lands
	logic [2:0] op_reg; // opcode last written
	logic [2:0] op_next;
	assign cmd_wr = psel && penable && pwrite && paddr == `PBAU_ADDR_CMD;
	// hold the opcode of the latest command
	always_comb begin
		op_next = !rstn ? 3'h0 : (cmd_wr ? pwdata[2:0] : op_reg);
	end
	always_ff @(posedge clk) begin
		op_reg <= op_next;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_inc_wdata: assert property (
		mem_wr && op_reg == `PBAU_OP_INC |-> mem_wdata == $past(mem_rdata) + 16'h1)
		else $error("increment write-back wrong");
	a_dec_wdata: assert property (
		mem_wr && op_reg == `PBAU_OP_DEC |-> mem_wdata == $past(mem_rdata) - 16'h1)
		else $error("decrement write-back wrong");
	a_rmw_spacing: assert property (
		mem_rd && op_reg inside {`PBAU_OP_INC, `PBAU_OP_DEC} |=> !mem_wr ##1 mem_wr && mem_addr == $past(mem_addr, 2))
		else $error("write-back missing or misplaced");
	a_wr_single: assert property (
		mem_wr |=> !mem_wr && !mem_rd)
		else $error("extra memory access after write");
	a_cmd_fetch: assert property (
		cmd_wr && (pwdata[2:0] inside {`PBAU_OP_INC, `PBAU_OP_DEC} || pwdata[4:0] == {2'h0, `PBAU_OP_DIV}) |=> mem_rd)
		else $error("operand fetch missing");
	a_bcd_no_mem: assert property (
		cmd_wr && pwdata[2:0] inside {`PBAU_OP_BADD, `PBAU_OP_BSUB} |=> (!mem_rd && !mem_wr) [*3])
		else $error("bcd operation touched memory");
	a_div_no_wr: assert property (
		mem_rd && op_reg == `PBAU_OP_DIV |=> !mem_wr [*3])
		else $error("divide wrote memory");
	a_imm_div_quiet: assert property (
		cmd_wr && pwdata[4:0] == {2'h2, `PBAU_OP_DIV} |=> (!mem_rd && !mem_wr) [*3])
		else $error("immediate divide used memory");
endmodule : pbau_arith_unit_props
bind pbau_arith_unit pbau_arith_unit_props #(.MEM_AW(MEM_AW)) i_pbau_arith_unit_props (.clk, .rstn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);

// [sim/tb_top.sv]
`timescale 1ns/100ps
`include "pbau_regs.svh"
// self-checking bench for the arithmetic unit
module tb_top;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr, irq, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q; // q holds the last read data
	logic [15:0] mem_addr, mem_wdata, mem_rdata;
	logic [255:0] disc_bits;
	logic [8:0] fl, fk; // expected flags and which are predictable
	logic [31:0] rr [5]; // range settings of refused commands
	logic [2:0] ro [5]; // opcodes of refused commands
	int error_cnt, cmp_count;
	localparam int FZ = `PBAU_FLAG_ZERO;
	localparam int FN = `PBAU_FLAG_NEG;
	pbau_arith_unit i_pbau_arith_unit (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .disc_bits, .irq);
	pbau_mem_model i_pbau_mem_model (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: got %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task stop_test;
		$display("mismatches %0d, comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : stop_test
	// one apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// issue a command and wait for idle
	task exec(input logic [31:0] c);
		apb(1'b1, `PBAU_ADDR_CMD, c);
		q = 32'h0;
		repeat (20) if (q !== 32'h1) apb(1'b0, `PBAU_ADDR_STATE, 32'h0);
		chk(q, 32'h1);
	endtask : exec
	task flags;
		apb(1'b0, `PBAU_ADDR_FLAGS, 32'h0);
		chk(q & 32'(fk), 32'(fl & fk));
	endtask : flags
	task div(input logic imm, input logic [15:0] a, input logic [31:0] d);
		logic [31:0] s0;
		logic bad;
		s0 = $urandom;
		bad = d == 32'h0 || d[31:16] != 16'h0;
		i_pbau_mem_model.mem[8'h10] = d[15:0];
		apb(1'b1, `PBAU_ADDR_ACC, {16'h0, a});
		apb(1'b1, `PBAU_ADDR_STACK1, s0);
		apb(1'b1, `PBAU_ADDR_OPERAND, imm ? d : 32'h10);
		exec({27'h0, imm, 1'b0, `PBAU_OP_DIV});
		fl[`PBAU_FLAG_RANGE] = bad;
		fk[FZ] = !bad;
		fk[FN] = !bad;
		if (!bad) begin
			fl[FZ] = a / d[15:0] == 16'h0;
			fl[FN] = 1'b0;
			s0 = {16'h0, a % d[15:0]};
			a = a / d[15:0];
		end
		apb(1'b0, `PBAU_ADDR_ACC, 32'h0);
		chk(q, {16'h0, a});
		apb(1'b0, `PBAU_ADDR_STACK1, 32'h0);
		chk(q, s0);
		flags;
	endtask : div
	task incdec(input logic dn, input logic [15:0] v);
		logic [7:0] a;
		a = 8'($urandom);
		i_pbau_mem_model.mem[a] = v;
		apb(1'b1, `PBAU_ADDR_OPERAND, {24'h0, a});
		exec(32'(dn ? `PBAU_OP_DEC : `PBAU_OP_INC));
		v = dn ? v - 16'h1 : v + 16'h1;
		fl[FZ] = v == 16'h0;
		fk[FZ] = 1'b1;
		chk(32'(i_pbau_mem_model.mem[a]), 32'(v));
		flags;
	endtask : incdec
	// digit-serial bcd add or subtract: {long carry, short carry, result}
	function automatic logic [33:0] bcd_as(input logic s, input logic [31:0] a, input logic [31:0] b);
		logic [4:0] d;
		logic c, sc;
		logic [31:0] r;
		c = 1'b0;
		sc = 1'b0;
		for (int i = 0; i < 8; i++) begin
			d = s ? {1'b0, a[4*i+:4]} - {1'b0, b[4*i+:4]} - 5'(c) : {1'b0, a[4*i+:4]} + {1'b0, b[4*i+:4]} + 5'(c);
			c = s ? d[4] : d > 5'h09;
			if (c) d = s ? d + 5'h0a : d + 5'h06;
			r[4*i+:4] = d[3:0];
			if (i == 3) sc = c;
		end
		return {c, sc, r};
	endfunction : bcd_as
	function automatic logic nb(input logic [31:0] x);
		logic n;
		n = 1'b0;
		for (int i = 0; i < 8; i++) n |= x[4*i+:4] > 4'h9;
		return n;
	endfunction : nb
	function automatic logic [31:0] rbcd();
		logic [31:0] r;
		for (int i = 0; i < 8; i++) r[4*i+:4] = 4'($urandom % 10);
		return r;
	endfunction : rbcd
	task bcd(input logic s, input logic [31:0] a, input logic [31:0] v, input logic [7:0] st, input logic [7:0] ln);
		logic [31:0] b;
		logic [33:0] r;
		logic inv;
		b = v & ~(32'hffffffff << ln);
		r = bcd_as(s, a, b);
		inv = nb(a) | nb(b);
		disc_bits[st+:32] <= v;
		apb(1'b1, `PBAU_ADDR_ACC, a);
		apb(1'b1, `PBAU_ADDR_RANGE, {16'h0, ln, st});
		exec(32'(s ? `PBAU_OP_BSUB : `PBAU_OP_BADD));
		fl[`PBAU_FLAG_INVDIG] = inv;
		fl[FZ] = r[31:0] == 32'h0;
		fl[FN] = s ? r[33] : r[31];
		fk[FZ] = !inv;
		fk[FN] = !inv;
		// sign rule on bit 31: add wants like signs, subtract unlike
		fl[`PBAU_FLAG_OVF] = (s ? a[31] != b[31] : a[31] == b[31]) && (r[31] != a[31]);
		fk[`PBAU_FLAG_OVF] = !inv;
		// borrow pair at 3:2, carry pair at 5:4
		if (s) begin
			fl[3:2] = r[33:32];
			fk[3:2] = {2{!inv}};
		end else begin
			fl[5:4] = r[33:32];
			fk[5:4] = {2{!inv}};
		end
		apb(1'b0, `PBAU_ADDR_ACC, 32'h0);
		if (!inv) chk(q, r[31:0]);
		flags;
	endtask : bcd
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test;
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata, err} = '0;
		error_cnt = 0;
		cmp_count = 0;
		fl = 9'h000;
		fk = 9'h17f;
		rr = '{32'h0100, 32'h0100, 32'h0100, 32'h0000, 32'h2100};
		ro = '{3'h0, 3'h6, 3'h7, 3'h4, 3'h5};
		void'($urandom(51));
		disc_bits = {8{$urandom}};
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		flags;
		apb(1'b1, `PBAU_ADDR_FLAGS, 32'h1ff);
		flags;
		apb(1'b0, 8'h24, 32'h0);
		chk({q[30:0], err}, 32'h1);
		div(1'b1, 16'h1234, 32'h0);
		div(1'b1, 16'h1234, 32'h10000);
		div(1'b0, 16'h0003, 32'h7);
		repeat (6) div(1'($urandom), 16'($urandom), {16'h0, 16'($urandom)});
		incdec(1'b0, 16'hffff);
		incdec(1'b1, 16'h0001);
		incdec(1'b1, 16'h0000);
		repeat (6) incdec(1'($urandom), 16'($urandom));
		bcd(1'b0, 32'h99999999, 32'h00000001, 8'h00, 8'h20);
		bcd(1'b1, 32'h00000000, 32'hffffff01, 8'h09, 8'h01);
		bcd(1'b0, 32'h00009999, 32'h00000001, 8'he0, 8'h04);
		bcd(1'b1, 32'h0000001a, 32'h00000001, 8'h03, 8'h08);
		repeat (12) bcd(1'($urandom), rbcd(), rbcd(), 8'($urandom % 225), 8'($urandom % 32 + 1));
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, `PBAU_ADDR_RANGE, rr[i]);
			apb(1'b1, `PBAU_ADDR_STATUS, 32'hf);
			exec(32'(ro[i]));
			apb(1'b0, `PBAU_ADDR_STATUS, 32'h0);
			chk(q, 32'h8);
		end
		apb(1'b1, `PBAU_ADDR_MASK, 32'h1);
		apb(1'b1, `PBAU_ADDR_STATUS, 32'hf);
		incdec(1'b0, 16'h1234);
		chk(32'(irq), 32'h1);
		apb(1'b1, `PBAU_ADDR_STATUS, 32'h1);
		apb(1'b0, `PBAU_ADDR_STATUS, 32'h0);
		chk({q[30:0], irq}, 32'h0);
		apb(1'b1, `PBAU_ADDR_MASK, 32'h0);
		incdec(1'b1, 16'h0001);
		apb(1'b0, `PBAU_ADDR_STATUS, 32'h0);
		chk({q[30:0], irq}, 32'h2);
		stop_test;
	end
endmodule : tb_top
